// ---- design/dttc_consts.svh ----
// constants of the debug triggered transfer client: field positions, reset values, encodings
`ifndef DTTC_CONSTS_SVH
`define DTTC_CONSTS_SVH

// ****************************************************************
// client configuration register fields
// ****************************************************************
`define DTTC_CFG_W          8
`define DTTC_CFG_RESET      8'h00
`define DTTC_CFG_TRIG       0
`define DTTC_CFG_EXT        1
`define DTTC_CFG_HW         2
`define DTTC_CFG_MOVE       3

// ****************************************************************
// client info register fields
// ****************************************************************
`define DTTC_INFO_W         8
`define DTTC_INFO_RESET     8'h00
`define DTTC_INFO_APPRST    0

// ****************************************************************
// addresses and bus encodings
// ****************************************************************
`define DTTC_TTA_RESET      32'h0010f068
`define DTTC_TTA_FIX_MASK   32'h01ffffff
`define DTTC_TTA_TOP_MASK   32'hff000000
`define DTTC_WORD_MASK      32'hfffffffc
`define DTTC_SIZE_WORD      2'h2
`define DTTC_SIZE_RESET     2'h2

`endif

// ---- design/dttc_pkg.sv ----
// types shared by the debug triggered transfer client modules
package dttc_pkg;

   // ****************************************************************
   // client state, one-hot
   // ****************************************************************
   typedef enum logic [3:0]
   {
      ST_IDLE  = 4'h1,
      ST_ERROR = 4'h2,
      ST_READ  = 4'h4,
      ST_WRITE = 4'h8
   } dttc_state_e;

   // ****************************************************************
   // tool command codes
   // ****************************************************************
   typedef enum logic [3:0]
   {
      CMD_NOP         = 4'h0,
      CMD_CONFIG      = 4'h1,
      CMD_SUPERVISOR  = 4'h2,
      CMD_SET_TRADDR  = 4'h3,
      CMD_SET_SRC     = 4'h4,
      CMD_READ_WORD   = 4'h5,
      CMD_READ_TRIG   = 4'h6,
      CMD_READ_INFO   = 4'h7,
      CMD_READ_CONFIG = 4'h8
   } dttc_cmd_e;

endpackage : dttc_pkg

// ---- design/dttc_cap_if.sv ----
// carrier between the client engine and the trigger holding store
`timescale 1ns/100ps
interface dttc_cap_if;
   logic        capValid;
   logic [31:0] capData;
   logic        trigMissed;
   logic        readWord;
   logic        readTrig;
   logic [31:0] holdData;
   logic        holdFull;
   logic        dirty;

   modport engine (output capValid, output capData, output trigMissed, output readWord, output readTrig,
                   input holdData, input holdFull, input dirty);
   modport store  (input capValid, input capData, input trigMissed, input readWord, input readTrig,
                   output holdData, output holdFull, output dirty);
endinterface : dttc_cap_if

// ---- design/dttc_trig_store.sv ----
// holding register and dirty bit of triggered transfers
`timescale 1ns/100ps
`include "dttc_consts.svh"
module dttc_trig_store
   import dttc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   dttc_cap_if.store cap
);

   // ****************************************************************
   // dirty bit bookkeeping
   // ****************************************************************
   logic        lastReadWord;
   logic        clearedDirty;
   logic [31:0] holdData;
   logic        holdFull;
   logic        dirty;
   wire         missSet = cap.trigMissed | (cap.capValid & holdFull);
   wire         undo    = cap.readTrig & lastReadWord;

   assign cap.holdData = holdData;
   assign cap.holdFull = holdFull;
   assign cap.dirty    = dirty;

   // newest word always replaces the held one; an overrun is what dirty reports
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         holdData <= 32'h0000_0000;
         holdFull <= 1'b0;
      end
      else
      begin
         if (cap.capValid)
            holdData <= cap.capData;
         holdFull <= cap.capValid | (holdFull & ~cap.readWord);
      end
   end

   // set beats clear; undo restores what the last word read cleared
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dirty        <= 1'b0;
         clearedDirty <= 1'b0;
         lastReadWord <= 1'b0;
      end
      else
      begin
         if (missSet)
            dirty <= 1'b1;
         else if (cap.readWord)
            dirty <= 1'b0;
         else if (undo)
            dirty <= clearedDirty;
         if (cap.readWord)
            clearedDirty <= dirty;
         if (cap.readWord)
            lastReadWord <= 1'b1;
         else if (cap.readTrig)
            lastReadWord <= 1'b0;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   dirtyClear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cap.readWord && !missSet |=> !dirty)
      else $error("dirty bit not cleared by word read");
   // the tool spaces its commands, so the trigger read is seldom in the very next cycle
   dirtyUndo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cap.readTrig && lastReadWord && !missSet |=> dirty == $past(clearedDirty))
      else $error("read trigger did not restore dirty bit");
   missSet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cap.trigMissed |=> dirty)
      else $error("missed trigger did not set dirty");
   overrun_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cap.capValid && holdFull |=> dirty && holdFull && holdData == $past(cap.capData))
      else $error("overrun capture lost or not flagged");

endmodule : dttc_trig_store

// ---- design/dttc_client.sv ----
// debug triggered transfer client: command decode, error state, bus engine
`timescale 1ns/100ps
`include "dttc_consts.svh"
// Operation
// - every triggered transfer is a word transaction
// - application reset clears the configuration register
// - application reset enters error, tool interaction suspended
// - info flags application reset; tool then reconfigures
// - word read returns data plus dirty bit
// - dirty bit cleared after each word read, unless a missed trigger or an overrun sets it in the same cycle
// - trigger read after word read restores dirty
// - external mode fixes target bits 24..0
// - internal mode uses full target register
module dttc_client
   import dttc_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic                    appReset,
   input  wire logic                    trigger,
   input  wire logic                    cmdValid,
   input  wire logic [3:0]              cmdCode,
   input  wire logic [31:0]             cmdData,
   output logic                         cmdReady,
   output logic                         respValid,
   output logic [31:0]                  respData,
   output logic                         respDirty,
   output logic                         clientError,
   output logic [`DTTC_CFG_W-1:0]       clientConfig,
   output logic [`DTTC_INFO_W-1:0]      clientInfo,
   output logic                         busReq,
   output logic                         busWrite,
   output logic [31:0]                  busAddr,
   output logic [31:0]                  busWdata,
   output logic [1:0]                   busSize,
   input  wire logic [31:0]             busRdata,
   input  wire logic                    busAck
);

   // ****************************************************************
   // state and registers
   // ****************************************************************
   dttc_state_e state;
   dttc_state_e next_state;
   logic [31:0] targetAddr;
   logic [31:0] sourceAddr;
   dttc_cap_if  cap ();

   dttc_trig_store u_store
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .cap     (cap)
   );

   // ****************************************************************
   // decode
   // ****************************************************************
   wire dttc_cmd_e cmd      = dttc_cmd_e'(cmdCode);
   wire            isIdle   = (state == ST_IDLE);
   wire            isError  = (state == ST_ERROR);
   wire            cmdTake  = cmdValid & cmdReady & ~appReset;
   wire            idleCmd  = cmdTake & isIdle;    // error state drops everything but supervisor
   wire            leaveErr = cmdTake & isError & (cmd == CMD_SUPERVISOR);
   wire            trigMode = clientConfig[`DTTC_CFG_TRIG];
   wire            extMode  = clientConfig[`DTTC_CFG_EXT];
   wire            moveMode = clientConfig[`DTTC_CFG_MOVE];
   wire            trigStart = isIdle & trigMode & trigger & ~idleCmd & ~appReset;
   wire            readDone  = (state == ST_READ) & busAck;
   wire            writeDone = (state == ST_WRITE) & busAck;
   // halfword select is deliberately not decoded: width is always a word
   wire [31:0]     effTarget = extMode ?
                   ((targetAddr & ~`DTTC_TTA_FIX_MASK) | (`DTTC_TTA_RESET & `DTTC_TTA_FIX_MASK)) :
                   targetAddr;
   wire [31:0]     newTarget = extMode ?
                   ((cmdData & `DTTC_TTA_TOP_MASK) | (targetAddr & ~`DTTC_TTA_TOP_MASK)) :
                   cmdData;
   wire            infoRead  = idleCmd & (cmd == CMD_READ_INFO);

   assign cap.capValid   = readDone;
   assign cap.capData    = busRdata;
   assign cap.trigMissed = trigMode & trigger & ~trigStart & ~isError;
   assign cap.readWord   = idleCmd & (cmd == CMD_READ_WORD);
   assign cap.readTrig   = idleCmd & (cmd == CMD_READ_TRIG);

   // next state; application reset overrides any transfer in flight
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:  if (trigStart) next_state = ST_READ;
         ST_ERROR: if (leaveErr) next_state = ST_IDLE;
         ST_READ:  if (busAck) next_state = moveMode ? ST_WRITE : ST_IDLE;
         ST_WRITE: if (busAck) next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
      if (appReset)
         next_state = ST_ERROR;
   end

   // state, ready and error outputs
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state       <= ST_IDLE;
         cmdReady    <= 1'b0;
         clientError <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         cmdReady    <= (next_state == ST_IDLE) | (next_state == ST_ERROR);
         clientError <= (next_state == ST_ERROR);
      end
   end

   // configuration, info and address registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clientConfig <= `DTTC_CFG_RESET;
         clientInfo   <= `DTTC_INFO_RESET;
         targetAddr   <= `DTTC_TTA_RESET;
         sourceAddr   <= 32'h0000_0000;
      end
      else
      begin
         if (appReset)
            clientConfig <= `DTTC_CFG_RESET;
         else if (idleCmd && cmd == CMD_CONFIG)
            clientConfig <= cmdData[`DTTC_CFG_W-1:0];
         // flag set wins over the read that clears it
         if (appReset)
            clientInfo[`DTTC_INFO_APPRST] <= 1'b1;
         else if (infoRead)
            clientInfo[`DTTC_INFO_APPRST] <= 1'b0;
         if (idleCmd && cmd == CMD_SET_TRADDR)
            targetAddr <= newTarget;
         if (idleCmd && cmd == CMD_SET_SRC)
            sourceAddr <= cmdData & `DTTC_WORD_MASK;
      end
   end

   // answers to the tool, one cycle after the command is taken
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         respValid <= 1'b0;
         respData  <= 32'h0000_0000;
         respDirty <= 1'b0;
      end
      else
      begin
         respValid <= 1'b0;
         respDirty <= 1'b0;
         if (idleCmd)
         begin
            unique case (cmd)
               CMD_READ_WORD:
               begin
                  respValid <= 1'b1;
                  respData  <= cap.holdData;
                  respDirty <= cap.dirty;
               end
               CMD_READ_TRIG:
               begin
                  respValid <= 1'b1;
                  respData  <= {31'h0000_0000, cap.holdFull};
               end
               CMD_READ_INFO:
               begin
                  respValid <= 1'b1;
                  respData  <= {24'h00_0000, clientInfo};
               end
               CMD_READ_CONFIG:
               begin
                  respValid <= 1'b1;
                  respData  <= {24'h00_0000, clientConfig};
               end
               default:
                  respValid <= 1'b0;
            endcase
         end
      end
   end

   // bus engine: read source, optionally write target, always a full word
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busReq   <= 1'b0;
         busWrite <= 1'b0;
         busAddr  <= 32'h0000_0000;
         busWdata <= 32'h0000_0000;
         busSize  <= `DTTC_SIZE_RESET;
      end
      else
      begin
         busSize <= `DTTC_SIZE_WORD;
         if (appReset || writeDone || (readDone && !moveMode))
         begin
            busReq   <= 1'b0;
            busWrite <= 1'b0;
         end
         else if (trigStart)
         begin
            busReq   <= 1'b1;
            busWrite <= 1'b0;
            busAddr  <= sourceAddr;
         end
         else if (readDone)
         begin
            busWrite <= 1'b1;
            busAddr  <= effTarget;
            busWdata <= busRdata;
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence readToMove;
      state == ST_READ && busAck && moveMode && !appReset;
   endsequence
   sequence writeIssued;
      busReq && busWrite && state == ST_WRITE;
   endsequence

   wordSize_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      busReq |-> busSize == `DTTC_SIZE_WORD)
      else $error("bus transfer not word sized");
   appRstCfg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      appReset |=> clientConfig == `DTTC_CFG_RESET && clientInfo[`DTTC_INFO_APPRST])
      else $error("application reset left configuration or info wrong");
   errorMute_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      appReset ##1 (!appReset && !leaveErr) [*3] |-> clientError && !respValid && !busReq)
      else $error("client active while in error state");
   moveSeq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      readToMove |=> writeIssued and busWdata == $past(busRdata))
      else $error("captured word not moved to target");
   extAddr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      readToMove and extMode |=> (busAddr & `DTTC_TTA_FIX_MASK) == (`DTTC_TTA_RESET & `DTTC_TTA_FIX_MASK))
      else $error("external target low bits not fixed");
   intAddr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      readToMove and !extMode |=> busAddr == $past(targetAddr))
      else $error("internal target not taken from register");
   wordDirty_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cap.readWord |=> respValid && respDirty == $past(cap.dirty) && respData == $past(cap.holdData))
      else $error("word read answer wrong");

endmodule : dttc_client

// ---- dv/dttc_bus_model.sv ----
// on-chip bus slave partner of the client: patterned word data, programmable wait
`timescale 1ns/100ps
module dttc_bus_model
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  waitCycles,
   input  wire logic        busReq,
   input  wire logic        busWrite,
   input  wire logic [31:0] busAddr,
   input  wire logic [31:0] busWdata,
   input  wire logic [1:0]  busSize,
   output logic [31:0]      busRdata,
   output logic             busAck,
   output logic [31:0]      rdAddr,
   output logic [31:0]      rdData,
   output logic [31:0]      wrAddr,
   output logic [31:0]      wrData,
   output logic [1:0]       lastSize,
   output logic [3:0]       nAcks
);
   logic [4:0] waitCnt;

   // one ack per phase after the wait; stale read data is inverted so it never matches by luck
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busAck <= 1'b0;
         busRdata <= 32'h00000000;
         waitCnt <= 5'h00;
         nAcks <= 4'h0;
      end
      else if (busAck)
      begin
         busAck <= 1'b0;
         busRdata <= ~busRdata;
         waitCnt <= 5'h00;
         nAcks <= nAcks + 4'h1;
         lastSize <= busSize;
         if (busWrite)
         begin
            wrAddr <= busAddr;
            wrData <= busWdata;
         end
         else
         begin
            rdAddr <= busAddr;
            rdData <= busRdata;
         end
      end
      else if (!busReq)
         waitCnt <= 5'h00;
      else if (waitCnt >= waitCycles)
      begin
         busAck <= 1'b1;
         busRdata <= {busAddr[15:0] ^ 16'h5ac3, busAddr[31:16]};
      end
      else
         waitCnt <= waitCnt + 5'h01;
   end
endmodule : dttc_bus_model

// ---- dv/dttc_client_test.sv ----
// self-checking bench of the triggered transfer client, tool side driven by command tasks
`timescale 1ns/100ps
`include "dttc_consts.svh"
module dttc_client_test;
   import dttc_pkg::*;
   logic        sys_clk, rst_n, appReset, trigger, cmdValid, cmdReady, respValid, respDirty, clientError;
   logic [3:0]  cmdCode, nAcks;
   logic [31:0] cmdData, respData, busAddr, busWdata, busRdata, rdAddr, rdData, wrAddr, wrData;
   logic [7:0]  clientConfig, clientInfo;
   logic        busReq, busWrite, busAck, gotResp, rDirty;
   logic [1:0]  busSize, lastSize;
   logic [4:0]  waitCycles;
   logic [31:0] rData;
   int          n_errors, num_checks;

   dttc_client dut (.sys_clk(sys_clk), .rst_n(rst_n), .appReset(appReset), .trigger(trigger),
      .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .cmdReady(cmdReady), .respValid(respValid),
      .respData(respData), .respDirty(respDirty), .clientError(clientError), .clientConfig(clientConfig),
      .clientInfo(clientInfo), .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata),
      .busSize(busSize), .busRdata(busRdata), .busAck(busAck));
   dttc_bus_model mem (.sys_clk(sys_clk), .rst_n(rst_n), .waitCycles(waitCycles), .busReq(busReq),
      .busWrite(busWrite), .busAddr(busAddr), .busWdata(busWdata), .busSize(busSize), .busRdata(busRdata),
      .busAck(busAck), .rdAddr(rdAddr), .rdData(rdData), .wrAddr(wrAddr), .wrData(wrData),
      .lastSize(lastSize), .nAcks(nAcks));

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic chk_word(input logic [31:0] exp, input logic [31:0] act);
      num_checks++;
      if (act !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask : chk_word

   task automatic chk_flag(input logic exp, input logic act);
      chk_word({31'h0, exp}, {31'h0, act});
   endtask : chk_flag

   // a wait that ran out is a mismatch and ends the run
   task automatic give_up(input logic timedOut);
      if (timedOut)
      begin
         n_errors++;
         complete_run();
      end
   endtask : give_up

   // request held until an edge sees ready; the answer is looked for over three cycles
   task automatic cmd(input dttc_cmd_e code, input logic [31:0] data);
      int   n;
      logic rdy;
      @(posedge sys_clk);
      cmdValid <= 1'b1;
      cmdCode <= code;
      cmdData <= data;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         rdy = cmdReady;
         @(posedge sys_clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 100);
      cmdValid <= 1'b0;
      give_up(rdy !== 1'b1);
      gotResp = 1'b0;
      repeat (3)
      begin
         @(negedge sys_clk);
         if (respValid === 1'b1 && !gotResp)
         begin
            gotResp = 1'b1;
            rData = respData;
            rDirty = respDirty;
         end
      end
   endtask : cmd

   // one trigger cycle, then wait until the bus has seen the given number of phases
   task automatic fire(input logic [3:0] acks);
      logic [3:0] goal;
      int         n;
      goal = nAcks + acks;
      @(posedge sys_clk);
      trigger <= 1'b1;
      @(posedge sys_clk);
      trigger <= 1'b0;
      n = 0;
      do
      begin
         @(negedge sys_clk);
         n++;
      end
      while ((nAcks !== goal || busReq !== 1'b0) && n < 100);
      give_up(nAcks !== goal || busReq !== 1'b0);
   endtask : fire

   // ****************************************************************
   // clock and test sequence
   // ****************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever
         #5 sys_clk = ~sys_clk;
   end

   initial
   begin
      rst_n = 1'b0;
      appReset = 1'b0;
      trigger = 1'b0;
      cmdValid = 1'b0;
      cmdCode = 4'h0;
      cmdData = 32'h00000000;
      waitCycles = 5'h00;
      n_errors = 0;
      num_checks = 0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk_word({30'h0, `DTTC_SIZE_WORD}, {30'h0, busSize});
      chk_word(32'h00000000, {24'h0, clientConfig});
      // word move with the halfword select set, internal target
      cmd(CMD_CONFIG, 32'h0000000d);
      chk_flag(1'b0, gotResp);
      cmd(CMD_READ_CONFIG, 32'h00000000);
      chk_word(32'h0000000d, rData);
      cmd(CMD_SET_SRC, 32'h00001000);
      cmd(CMD_SET_TRADDR, 32'h20000040);
      fire(4'h2);
      chk_word(32'h00001000, rdAddr);
      chk_word(32'h20000040, wrAddr);
      chk_word(rdData, wrData);
      chk_word({30'h0, `DTTC_SIZE_WORD}, {30'h0, lastSize});
      cmd(CMD_READ_WORD, 32'h00000000);
      chk_word(rdData, rData);
      chk_flag(1'b0, rDirty);
      // overrun of the holding register, then the trigger read quirk
      fire(4'h2);
      fire(4'h2);
      cmd(CMD_READ_WORD, 32'h00000000);
      chk_flag(1'b1, rDirty);
      cmd(CMD_READ_TRIG, 32'h00000000);
      cmd(CMD_READ_WORD, 32'h00000000);
      chk_flag(1'b1, rDirty);
      cmd(CMD_READ_WORD, 32'h00000000);
      chk_flag(1'b0, rDirty);
      // external target: only the top bits follow the command
      cmd(CMD_CONFIG, 32'h0000000b);
      cmd(CMD_SET_TRADDR, 32'hab10f068);
      fire(4'h2);
      chk_word(32'haa10f068, wrAddr);
      // application reset in mid transfer on a slow bus
      @(posedge sys_clk);
      waitCycles <= 5'h14;
      trigger <= 1'b1;
      @(posedge sys_clk);
      trigger <= 1'b0;
      repeat (3) @(posedge sys_clk);
      appReset <= 1'b1;
      @(posedge sys_clk);
      appReset <= 1'b0;
      @(negedge sys_clk);
      chk_flag(1'b0, busReq);
      chk_flag(1'b1, clientError);
      chk_word(32'h00000000, {24'h0, clientConfig});
      chk_flag(1'b1, clientInfo[`DTTC_INFO_APPRST]);
      cmd(CMD_READ_CONFIG, 32'h00000000);
      chk_flag(1'b0, gotResp);
      cmd(CMD_CONFIG, 32'h0000000d);
      chk_word(32'h00000000, {24'h0, clientConfig});
      cmd(CMD_SUPERVISOR, 32'h00000000);
      chk_flag(1'b0, clientError);
      cmd(CMD_READ_INFO, 32'h00000000);
      chk_word(32'h00000001, rData);
      cmd(CMD_CONFIG, 32'h0000000d);
      cmd(CMD_READ_CONFIG, 32'h00000000);
      chk_word(32'h0000000d, rData);
      @(posedge sys_clk);
      waitCycles <= 5'h03;
      fire(4'h2);
      cmd(CMD_READ_WORD, 32'h00000000);
      chk_word(rdData, rData);
      // capture only, trigger held a second cycle so one event is missed in flight
      cmd(CMD_CONFIG, 32'h00000001);
      @(posedge sys_clk);
      trigger <= 1'b1;
      fire(4'h1);
      chk_word(32'hab000040, wrAddr);
      cmd(CMD_READ_WORD, 32'h00000000);
      chk_flag(1'b1, gotResp);
      chk_word(rdData, rData);
      chk_flag(1'b1, rDirty);
      complete_run();
   end
endmodule : dttc_client_test
